/* fwa_alert_core.sv */
// Fault/warning status latching and the two open-drain alert pins,
// with latched alert mode, live comparator mode and alert response.
// Assumes fault, breaker and bus pins are asynchronous; monitor values,
// limits, commands and configuration come from logic on i_mclk.
`timescale 1ns/100ps
`default_nettype none
module fwa_alert_core
  import fwa_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Analog fault and breaker conditions
  input wire logic [NFAULT-1:0] i_fault_cond,
  input wire logic i_breaker_trip,
  // Warning sources on the core clock
  input wire logic i_comm_err,
  input wire logic i_mon_sample,
  input wire logic [NMON-1:0][MON_W-1:0] i_mon_value,
  input wire logic [NMON-1:0][MON_W-1:0] i_warn_limit,
  input wire logic i_hyst_warn,
  // Commands
  input wire logic i_clear_all,
  input wire logic i_op_on,
  // Configuration
  input wire logic [NSTAT-1:0] i_alert_enable_mask,
  input wire logic [NSTAT-1:0] i_second_alert_enable_mask,
  input wire logic [1:0] i_alert_invert,
  input wire logic [1:0] i_alert_cmp_mode,
  input wire logic [ADDR_W-1:0] i_own_addr,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Alert pins
  output logic o_first_alert_output_out,
  output logic o_first_alert_output_oe,
  output logic o_second_alert_output_out,
  output logic o_second_alert_output_oe,
  // Status and hot swap gate enable
  output logic [NSTAT-1:0] o_status,
  output logic o_hs_enable
);

  logic [NFAULT-1:0] fault_s1_r;
  logic [NFAULT-1:0] fault_s2_r;
  logic brk_s1_r;
  logic brk_s2_r;
  logic [NSTAT-1:0] status_r;
  logic [NSTAT-1:0] status_nxt;
  logic [NSTAT-1:0] live_r;
  logic op_on_d_r;
  logic trip_r;
  logic hs_en_r;
  logic [1:0] pend_r;
  logic [1:0] pin_oe_r;

  fwa_ara_if ara ();

  // Two-stage synchronisers for asynchronous conditions
  always_ff @(posedge i_mclk)
  begin
    fault_s1_r <= i_sys_rst ? '0 : i_fault_cond;
    fault_s2_r <= i_sys_rst ? '0 : fault_s1_r;
    brk_s1_r <= i_sys_rst ? 1'b0 : i_breaker_trip;
    brk_s2_r <= i_sys_rst ? 1'b0 : brk_s1_r;
  end

  // Strict comparisons; the offset-binary current code orders like an
  // unsigned number, so no sign handling is needed around CUR_ZERO_CODE
  wire [NMON-1:0] mon_hit;
  genvar g;
  generate
    for (g = 0; g < NMON; g++)
    begin : g_cmp
      assign mon_hit[g] = MON_OVER[g] ?
        (i_mon_value[g] > i_warn_limit[g]) :
        (i_mon_value[g] < i_warn_limit[g]);
    end
  endgenerate

  // Threshold result of the current inputs in status bit order, taken only on a sample
  wire [NSTAT-1:0] mon_vec = {i_hyst_warn, mon_hit,
                              {(NSTAT-NMON-1){1'b0}}};

  // Event vector: faults and warnings are never masked; monitor warnings enter only on a sample
  wire [NSTAT-1:0] set_vec;
  assign set_vec[NFAULT-1:0] = fault_s2_r;
  assign set_vec[ST_COMM_ERR] = i_comm_err;
  assign set_vec[ST_BREAKER] = brk_s2_r;
  assign set_vec[NSTAT-1:ST_MON_BASE] =
    i_mon_sample ? mon_vec[NSTAT-1:ST_MON_BASE] : '0;

  wire op_rise = i_op_on & ~op_on_d_r;
  wire clr_status = i_clear_all | op_rise;

  // Set wins over clear, so active conditions stay latched
  assign status_nxt = (clr_status ? '0 : status_r) | set_vec;

  // New events only: compared against the registered previous copy
  wire [NSTAT-1:0] rise_vec = set_vec & ~status_r;

  wire [1:0][NSTAT-1:0] mask;
  assign mask[0] = i_alert_enable_mask;
  assign mask[1] = i_second_alert_enable_mask;

  wire [1:0] hit_new;
  wire [1:0] cmp_act;
  wire [1:0] configured;
  wire [1:0] pin_active;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      assign hit_new[g] = |(rise_vec & mask[g]);
      assign cmp_act[g] = |(live_r & mask[g]);
      assign configured[g] = |mask[g];
      assign pin_active[g] = i_alert_cmp_mode[g] ? cmp_act[g] : pend_r[g];
    end
  endgenerate

  // Both pins share one release so latched-mode pins go inactive together; comparator-mode pins follow live_r
  wire alert_clr = i_clear_all | ara.won;
  wire [1:0] pend_nxt = (alert_clr ? 2'h0 : pend_r) | hit_new;

  // Open-drain: drive low when active and not inverted, or the reverse
  wire [1:0] drive_low = (pin_active ^ i_alert_invert) & configured;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      status_r <= '0;
      live_r <= '0;
      op_on_d_r <= 1'b0;
      pend_r <= 2'h0;
      pin_oe_r <= 2'h0;
    end
    else
    begin
      status_r <= status_nxt;
      if (i_mon_sample)
        live_r <= mon_vec;
      op_on_d_r <= i_op_on;
      pend_r <= pend_nxt;
      pin_oe_r <= drive_low;
    end
  end

  // Only faults trip the gate; an off-on command re-arms it
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      trip_r <= 1'b0;
      hs_en_r <= 1'b0;
    end
    else
    begin
      trip_r <= (|fault_s2_r) | (trip_r & ~op_rise);
      hs_en_r <= i_op_on & ~(|fault_s2_r) & ~(trip_r & ~op_rise);
    end
  end

  assign ara.alert_pend = |(pend_r & configured & ~i_alert_cmp_mode);
  assign ara.own_addr = i_own_addr;

  fwa_ara_resp u_ara (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .ara(ara)
  );

  assign o_sda_out = 1'b0;
  assign o_first_alert_output_out = 1'b0;
  assign o_first_alert_output_oe = pin_oe_r[0];
  assign o_second_alert_output_out = 1'b0;
  assign o_second_alert_output_oe = pin_oe_r[1];
  assign o_status = status_r;
  assign o_hs_enable = hs_en_r;

endmodule
`default_nettype wire

/* fwa_alert_core_asserts.sv */
// Port-level checks on the alert core.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module fwa_alert_core_asserts
  import fwa_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Watched inputs
  input wire logic [NFAULT-1:0] i_fault_cond,
  input wire logic i_clear_all,
  input wire logic i_op_on,
  input wire logic [NSTAT-1:0] i_alert_enable_mask,
  input wire logic [1:0] i_alert_cmp_mode,
  input wire logic [1:0] i_alert_invert,
  // Watched outputs
  input wire logic o_first_alert_output_oe,
  input wire logic o_second_alert_output_oe,
  input wire logic [NSTAT-1:0] o_status,
  input wire logic o_hs_enable
);
  logic [NSTAT-1:0] prev_r;
  logic op_q_r;
  logic rise1, plain, oe1, oe2, op_rise;
  assign rise1 = |(i_alert_enable_mask & o_status & ~prev_r);
  assign plain = (i_alert_cmp_mode == 2'h0) && (i_alert_invert == 2'h0);
  assign oe1 = o_first_alert_output_oe;
  assign oe2 = o_second_alert_output_oe;
  assign op_rise = i_op_on & ~op_q_r;
  always_ff @(posedge i_mclk)
  begin
    prev_r <= o_status;
    op_q_r <= i_op_on;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_reset_quiet;
    $fell(i_sys_rst) |-> !oe1 && !oe2 && o_status == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pin or status active after reset");
  property p_cfg_quiet;
    (i_alert_enable_mask == '0) [*3] |-> !oe1;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("pin driven with empty mask");
  property p_rel_together;
    ($fell(oe1) || $fell(oe2)) && plain |-> !oe1 && !oe2;
  endproperty
  a_rel_together: assert property (p_rel_together)
    else $error("pins released apart");
  // Op rise may be seen one edge late if the design registers it first
  property p_hold_status;
    |(prev_r & ~o_status) |->
      $past(i_clear_all || op_rise) || $past(op_rise, 2);
  endproperty
  a_hold_status: assert property (p_hold_status)
    else $error("status bit dropped without clear");
  property p_fault_sets;
    $stable(i_fault_cond) [*5] |->
      (o_status[NFAULT-1:0] & i_fault_cond) == i_fault_cond;
  endproperty
  a_fault_sets: assert property (p_fault_sets)
    else $error("fault status not set");
  property p_fault_trips;
    i_fault_cond != '0 |-> ##[1:4] !o_hs_enable;
  endproperty
  a_fault_trips: assert property (p_fault_trips)
    else $error("gate stays on under fault");
  property p_warn_keeps_gate;
    $fell(o_hs_enable) && i_op_on && $past(i_op_on) |->
      ##[0:1] o_status[NFAULT-1:0] != '0;
  endproperty
  a_warn_keeps_gate: assert property (p_warn_keeps_gate)
    else $error("gate off without fault");
  property p_alert_cause;
    $rose(oe1) && plain |-> $past(rise1);
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert without new enabled status");
  c_pin1: cover property ($rose(oe1));
  c_pin2: cover property ($fell(oe2));
  c_trip: cover property ($fell(o_hs_enable));
endmodule
bind fwa_alert_core fwa_alert_core_asserts u_asserts (.i_mclk, .i_sys_rst,
  .i_fault_cond, .i_clear_all, .i_op_on, .i_alert_enable_mask,
  .i_alert_cmp_mode, .i_alert_invert, .o_first_alert_output_oe,
  .o_second_alert_output_oe, .o_status, .o_hs_enable);
`default_nettype wire

/* fwa_alert_core_tb_top.sv */
// Self-checking bench for the fault/warning alert core.
// Assumes the host model on the bus pins and pull-ups on all lines.
`timescale 1ns/100ps
`default_nettype none
module fwa_alert_core_tb_top
  import fwa_pkg::*;
;
  logic i_mclk, i_sys_rst, i_breaker_trip, i_comm_err, i_mon_sample;
  logic i_hyst_warn, i_clear_all, i_op_on, i_scl, i_sda, o_sda_out;
  logic o_sda_oe, o_first_alert_output_out, o_first_alert_output_oe;
  logic o_second_alert_output_out, o_second_alert_output_oe, o_hs_enable;
  logic [NFAULT-1:0] i_fault_cond;
  logic [NMON-1:0][MON_W-1:0] i_mon_value, i_warn_limit;
  logic [NSTAT-1:0] i_alert_enable_mask, i_second_alert_enable_mask, o_status;
  logic [1:0] i_alert_invert, i_alert_cmp_mode, pins;
  logic [ADDR_W-1:0] i_own_addr;
  logic [7:0] rb;
  logic ack, hsda;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  assign pins = {o_first_alert_output_oe, o_second_alert_output_oe};
  assign i_sda = hsda & ~(o_sda_oe & ~o_sda_out);
  fwa_smb_host host (.i_sda_line(i_sda), .o_scl(i_scl), .o_sda(hsda));
  fwa_alert_core dut (.i_mclk, .i_sys_rst, .i_fault_cond, .i_breaker_trip,
    .i_comm_err, .i_mon_sample, .i_mon_value, .i_warn_limit, .i_hyst_warn,
    .i_clear_all, .i_op_on, .i_alert_enable_mask,
    .i_second_alert_enable_mask, .i_alert_invert, .i_alert_cmp_mode,
    .i_own_addr, .i_scl, .i_sda, .o_sda_out, .o_sda_oe,
    .o_first_alert_output_out, .o_first_alert_output_oe,
    .o_second_alert_output_out, .o_second_alert_output_oe, .o_status,
    .o_hs_enable);
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic both(input logic [14:0] st, input logic [1:0] p);
    chk("status", {1'b0, st}, {1'b0, o_status});
    chk("pins", {14'h0, p}, {14'h0, pins});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic smp(input logic [15:0] v);
    i_mon_value[3] = v;
    pulse(i_mon_sample);
    tick(4);
  endtask
  task automatic clear();
    pulse(i_clear_all);
    tick(4);
  endtask
  initial
  begin
    {i_sys_rst, i_breaker_trip, i_comm_err, i_mon_sample} = 4'h8;
    {i_hyst_warn, i_clear_all, i_op_on} = 3'h0;
    {i_fault_cond, i_mon_value, i_warn_limit} = '0;
    {i_alert_enable_mask, i_second_alert_enable_mask} = '0;
    {i_alert_invert, i_alert_cmp_mode} = 4'h0;
    i_own_addr = 7'h2a;
    tick(2);
    i_sys_rst = 1'b0;
    tick(4);
    both(15'h0000, 2'h0);
    i_warn_limit[3] = 16'h0400;
    i_alert_enable_mask = 15'h0420;
    i_second_alert_enable_mask = 15'h0001;
    i_op_on = 1'b1;
    smp(16'h0400);
    pulse(i_comm_err);
    pulse(i_breaker_trip);
    tick(5);
    both(15'h0060, 2'h2);
    chk("gate", 16'h1, {15'h0, o_hs_enable});
    $display("test warnings done");
    clear();
    both(15'h0000, 2'h0);
    smp(16'h03ff);
    both(15'h0400, 2'h2);
    clear();
    both(15'h0000, 2'h0);
    smp(16'h03ff);
    both(15'h0400, 2'h2);
    host.ara_read(rb, ack, 8'hff);
    tick(4);
    chk("ara ack", 16'h0, {15'h0, ack});
    chk("ara addr", {9'h0, i_own_addr}, {9'h0, rb[7:1]});
    both(15'h0400, 2'h0);
    smp(16'h03ff);
    both(15'h0400, 2'h0);
    pulse(i_comm_err);
    tick(4);
    both(15'h0420, 2'h2);
    // A lower address answers too, so this device must back off
    host.ara_read(rb, ack, 8'h21);
    tick(4);
    chk("ara lost", 16'h0021, {8'h0, rb});
    both(15'h0420, 2'h2);
    clear();
    both(15'h0000, 2'h0);
    $display("test response done");
    i_fault_cond = 5'h01;
    tick(6);
    both(15'h0001, 2'h1);
    chk("gate", 16'h0, {15'h0, o_hs_enable});
    clear();
    both(15'h0001, 2'h0);
    i_fault_cond = 5'h00;
    tick(4);
    clear();
    both(15'h0000, 2'h0);
    i_op_on = 1'b0;
    tick(2);
    i_op_on = 1'b1;
    tick(4);
    chk("gate", 16'h1, {15'h0, o_hs_enable});
    $display("test faults done");
    i_second_alert_enable_mask = 15'h0400;
    i_alert_cmp_mode = 2'h2;
    smp(16'h03ff);
    chk("live", 16'h1, {15'h0, o_second_alert_output_oe});
    smp(16'h0401);
    chk("live", 16'h0, {15'h0, o_second_alert_output_oe});
    // Inverted pin pulls low while its condition is inactive
    i_alert_invert = 2'h2;
    tick(2);
    chk("inverted", 16'h1, {15'h0, o_second_alert_output_oe});
    $display("test comparator done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* fwa_ara_if.sv */
// Link between the alert core and its alert-response responder.
// Assumes both ends share the core clock.
`timescale 1ns/100ps
`default_nettype none
interface fwa_ara_if;
  import fwa_pkg::*;
  logic alert_pend;
  logic [ADDR_W-1:0] own_addr;
  logic won;
  modport core (output alert_pend, output own_addr, input won);
  modport resp (input alert_pend, input own_addr, output won);
endinterface
`default_nettype wire

/* fwa_ara_resp.sv */
// Alert response address responder: answers a receive byte at the
// alert response address with the own address, optionally with PEC.
// Assumes scl and sda pins arrive asynchronously; the bus is slow
// against the clock so edges are found by sampling.
`timescale 1ns/100ps
`default_nettype none
module fwa_ara_resp
  import fwa_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // Core link
  fwa_ara_if.resp ara
);

  logic [2:0] scl_r;
  logic [2:0] sda_r;
  fwa_ara_e state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] addr_byte_r;
  logic drv_r;
  logic won_r;

  // Stage 0 feeds only stage 1; edges use stages 1 and 2
  always_ff @(posedge i_mclk)
  begin
    scl_r <= i_sys_rst ? 3'h7 : {scl_r[1:0], i_scl};
    sda_r <= i_sys_rst ? 3'h7 : {sda_r[1:0], i_sda};
  end

  wire scl_rise = scl_r[1] & ~scl_r[2];
  wire scl_fall = ~scl_r[1] & scl_r[2];
  wire sda_now = sda_r[1];
  wire bus_start = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1];
  wire bus_stop = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1];
  wire [7:0] ara_rd = {ARA_ADDR, 1'b1};
  wire hit = (shift_r == ara_rd) & ara.alert_pend;
  wire [7:0] my_byte = {ara.own_addr, 1'b1};
  wire [7:0] pec_byte = fwa_crc8(fwa_crc8(8'h00, ara_rd), addr_byte_r);
  wire [7:0] tx_byte = (state_r == AR_PEC) ? pec_byte : addr_byte_r;
  wire last_bit = (cnt_r == ACK_SLOT);
  wire [2:0] bit_sel = 3'(7 - cnt_r[2:0]);
  // Released one while the bus reads low: a lower address is winning
  wire lost = tx_byte[bit_sel] & ~sda_now;

  always_ff @(posedge i_mclk)
  begin
    won_r <= 1'b0;
    if (i_sys_rst | bus_stop)
    begin
      state_r <= AR_IDLE;
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
    end
    else if (bus_start)
    begin
      state_r <= AR_ADDR;
      cnt_r <= 4'h0;
      drv_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (state_r)
        AR_IDLE: cnt_r <= 4'h0;
        AR_ADDR:
        begin
          if (!last_bit)
          begin
            shift_r <= {shift_r[6:0], sda_now};
            cnt_r <= cnt_r + 4'h1;
          end
          else
          begin
            state_r <= hit ? AR_SEND : AR_IDLE;
            addr_byte_r <= my_byte;
            cnt_r <= 4'h0;
          end
        end
        AR_SEND, AR_PEC:
        begin
          if (!last_bit && lost)
          begin
            state_r <= AR_IDLE;
            drv_r <= 1'b0;
          end
          else if (!last_bit)
            cnt_r <= cnt_r + 4'h1;
          else
          begin
            // Released in the acknowledge slot after the address byte
            won_r <= (state_r == AR_SEND);
            state_r <= (state_r == AR_SEND && !sda_now) ? AR_PEC : AR_IDLE;
            cnt_r <= 4'h0;
          end
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        AR_IDLE: drv_r <= 1'b0;
        AR_ADDR: drv_r <= last_bit & hit;
        AR_SEND, AR_PEC: drv_r <= ~last_bit & ~tx_byte[bit_sel];
      endcase
    end
  end

  assign o_sda_oe = drv_r;
  assign ara.won = won_r;

endmodule
`default_nettype wire

/* fwa_pkg.sv */
// Constants and types shared by the fault/warning alert logic.
// Assumes a single 100 MHz clock domain; the bus pins are sampled, not clocked.
// Functional notes
// - Faults are always watched, never maskable.
// - Any fault turns output off, sets status.
// - Status one means fault/warning; bits stay latched.
// - Clear only on clear-all or output off-on.
// - Warnings never change the output state.
// - Ten warning sources feed the status bits.
// - Breaker trip sets its warning even without shutdown.
// - Alert pins released and disabled until configured.
// - Per-pin enable mask; active low, optional inversion.
// - Alert only on enabled bit rising zero-to-one.
// - Pins assert independently, always released together; comparator-mode pins follow live_r instead.
// - Clear-all releases alerts; persistent faults stay silent.
// - Live monitor warning re-sets on next sample.
// - Answer receive byte at alert response address.
// - Answer byte carries own address in top seven.
// - Lowest address wins; only winner releases alert.
// - Winner releases during the following not-acknowledge bit; the code releases in the slot after the address byte, acknowledged or not.
// - After answering, stay quiet until clear or event.
// - Comparator mode follows live threshold result unlatched.
// - Comparator selection uses the same enable mask.
// - Readings raw 12-bit; current offset binary at 2048.
// - Comparisons strict; equality raises no warning.
package fwa_pkg;

  localparam int NSTAT = 15;
  localparam int NFAULT = 5;
  localparam int NMON = 7;
  localparam int MON_W = 16;
  localparam int ADDR_W = 7;

  // Status bit positions
  localparam int ST_UV = 0;
  localparam int ST_OV = 1;
  localparam int ST_OC_TIMEOUT = 2;
  localparam int ST_OT_FAULT = 3;
  localparam int ST_FET = 4;
  localparam int ST_COMM_ERR = 5;
  localparam int ST_BREAKER = 6;
  localparam int ST_MON_BASE = 7;
  localparam int ST_HYST = 14;

  // Monitor channels: 0 iout oc, 1 vin uv, 2 vin ov, 3 vout uv,
  // 4 vout ov, 5 pin op, 6 ot warn. A one means an over-limit check.
  localparam logic [NMON-1:0] MON_OVER = 7'h75;

  // Zero sense voltage code of the offset-binary current reading
  localparam logic [11:0] CUR_ZERO_CODE = 12'h800;

  localparam logic [ADDR_W-1:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [3:0] {
    AR_IDLE = 4'b0001,
    AR_ADDR = 4'b0010,
    AR_SEND = 4'b0100,
    AR_PEC = 4'b1000
  } fwa_ara_e;

  // One byte step of the SMBus packet error code
  function automatic logic [7:0] fwa_crc8(input logic [7:0] crc,
                                          input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
    begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

endpackage

/* fwa_smb_host.sv */
// SMBus host model that issues alert response reads.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`timescale 1ns/100ps
`default_nettype none
module fwa_smb_host
(
  // Bus lines
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One bit slot of 80 ns; data moves only while SCL is low
  task automatic slot(input logic b, output logic s);
    o_sda = b;
    #40 o_scl = 1'b1;
    #20 s = i_sda_line;
    #20 o_scl = 1'b0;
  endtask
  // Caller repeats this while the alert line stays low
  // Other is the byte a second alerting device puts on the wired-AND line
  task automatic ara_read(output logic [7:0] d, output logic ack,
                          input logic [7:0] other);
    logic [7:0] a;
    logic s;
    a = 8'h19;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      slot(a[i], s);
    end
    slot(1'b1, ack);
    for (int i = 7; i >= 0; i--)
    begin
      slot(other[i], d[i]);
    end
    // No acknowledge: the read ends without PEC
    slot(1'b1, s);
    o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
  endtask
endmodule
`default_nettype wire
